// ### bench/tb.sv
// Self-checking bench of the 16-bit timer core, with a behavioural model of count and flags.
// Assumes APB with zero wait states and a bench-driven tick, held low during register access.
`timescale 1ns/1ps
module tb;
    import tmr16_pkg::*;
    logic        clk = 0, rstn = 0, tick = 0, svc = 0, psel = 0, pen = 0, pwr = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, wa, wa_oen, wb, wb_oen, pin, oos;
    tmr16_mode_t mode;
    int          mismatches = 0, checks_done = 0, mcnt, mtop, mcmpa, mcmpb, mbufa, mbufb;
    bit [3:0]    mmode, mflg;
    bit [1:0]    mcoma, mcomb;
    bit          mdira, mdirb, mwa, mwb, mblk;
    logic [15:0] seed = 16'h00B1;
    bit [3:0]    modes[5] = '{4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
    bit [1:0]    coms[5] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h1};
    always #2.5 clk = ~clk;
    tmr16_core tmr16_core_i (.i_clk(clk), .i_rstn(rstn), .i_tick(tick), .i_ovf_serviced(svc),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_wave_a(wa),
        .o_wave_a_oen(wa_oen), .o_wave_b(wb), .o_wave_b_oen(wb_oen), .o_out_of_scope(oos),
        .o_mode(mode));
    tmr16_load tmr16_load_i (.i_clk(clk), .i_rstn(rstn), .i_wave(wa), .i_oen(wa_oen),
        .o_pin(pin));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic int mcls(input bit [3:0] m);
        case (m)
            4'h0: return 1;
            4'h4, 4'hC: return 2;
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF: return 4;
            default: return 8;
        endcase
    endfunction : mcls
    function automatic bit act(input bit [1:0] c, input bit w);
        return c == 2'h1 ? !w : c == 2'h2 ? 1'b0 : c == 2'h3 ? 1'b1 : w;
    endfunction : act
    // Next level of one waveform bit for one timer tick.
    function automatic bit wv(input bit [1:0] c, input bit w, input bit m, input bit tp,
                              input bit pw, input bit tg);
        if (!pw) return m ? act(c, w) : w;
        if (c == 2'h1) return (m && tg) ? !w : w;
        if (c == 2'h0) return w;
        if (tp) return c == 2'h2;
        return m ? c == 2'h3 : w;
    endfunction : wv
    function automatic void mstep();
        int top;
        bit tp, ma, mb, pw;
        if (mcls(mmode) == 8) return;
        pw = mcls(mmode) == 4;
        case (mmode)
            4'h4, 4'hF: top = mcmpa;
            4'hC, 4'hE: top = mtop;
            4'h5: top = 'hFF;
            4'h6: top = 'h1FF;
            4'h7: top = 'h3FF;
            default: top = -1;
        endcase
        tp = !mblk && mcnt == top;
        ma = !mblk && mcnt == mcmpa;
        mb = !mblk && mcnt == mcmpb;
        mflg[0] |= mcnt == 'hFFFF || (pw && tp);
        mflg[1] |= ma;
        mflg[2] |= mb;
        mflg[3] |= tp && (mmode == 4'hC || mmode == 4'hE);
        mwa = wv(mcoma, mwa, ma, tp, pw, mmode == 4'hF);
        mwb = wv(mcomb, mwb, mb, tp, pw, 1'b0);
        if (pw && tp) begin
            mcmpa = mbufa;
            mcmpb = mbufb;
        end
        mcnt = tp ? 0 : (mcnt + 1) & 'hFFFF;
        mblk = 0;
    endfunction : mstep
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rdat, output logic err);
        int n;
        psel <= 1;
        pen <= 0;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            summarize();
        end
        rdat = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
        // One idle cycle keeps the next setup from reassigning psel in this time step.
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rv;
        logic        err;
        int          v;
        apb(1, a, d, rv, err);
        v = d & (mmode == 4'h5 ? 'hFF : mmode == 4'h6 ? 'h1FF : mmode == 4'h7 ? 'h3FF : 'hFFFF);
        case (a)
            OFS_CTRL: begin
                mmode = d[3:0];
                mcoma = d[5:4];
                mdira = d[8];
                mcomb = d[7:6];
                mdirb = d[9];
            end
            OFS_COUNT: begin
                mcnt = d[15:0];
                mblk = 1;
            end
            OFS_CMP_A: begin
                mbufa = v;
                if (mcls(mmode) != 4) mcmpa = v;
            end
            OFS_CMP_B: begin
                mbufb = v;
                if (mcls(mmode) != 4) mcmpb = v;
            end
            OFS_TOP: mtop = d[15:0];
            OFS_FLAGS: mflg &= ~d[3:0];
            OFS_FORCE: begin
                if (d[0] && mcls(mmode) != 4) mwa = act(mcoma, mwa);
                if (d[1] && mcls(mmode) != 4) mwb = act(mcomb, mwb);
            end
            default: ;
        endcase
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] v;
        logic        err;
        apb(0, a, 32'h0, v, err);
        check(nm, v, exp);
    endtask : rd
    task automatic ticks(input int n);
        tick <= 1;
        repeat (n) begin
            @(posedge clk);
            mstep();
        end
        tick <= 0;
    endtask : ticks
    task automatic chk();
        rd(OFS_COUNT, mcnt, "count");
        rd(OFS_FLAGS, mflg, "flags");
        check("wave", wa, mwa);
        check("oen", wa_oen, !(mdira && mcoma != 2'h0));
        if (wa_oen === 1'b0) check("pin", pin, mwa);
        check("wave_b", wb, mwb);
        check("oen_b", wb_oen, !(mdirb && mcomb != 2'h0));
        check("mode", 32'(mode), mcls(mmode));
        check("scope", oos, mcls(mmode) == 8);
    endtask : chk
    initial begin
        logic [31:0] v;
        logic        err;
        int          t;
        repeat (2) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        chk();
        apb(0, 8'h1C, 32'h0, v, err);
        check("unmapped_err", err, 32'h1);
        check("unmapped_data", v, 32'h0);
        wr(OFS_CMP_A, 32'h0000FFFE);
        wr(OFS_COUNT, 32'h0000FFFC);
        for (int i = 0; i < 6; i++) begin
            ticks(1);
            chk();
        end
        svc <= 1;
        @(posedge clk);
        svc <= 0;
        mflg[0] = 0;
        chk();
        wr(OFS_FLAGS, 32'h0000000F);
        seed = lfsr(seed);
        wr(OFS_CMP_B, {16'h0, seed});
        wr(OFS_COUNT, {16'h0, seed});
        ticks(2);
        chk();
        wr(OFS_CTRL, 32'h000003F0);
        wr(OFS_FORCE, 32'h00000003);
        chk();
        wr(OFS_CTRL, 32'h00000114);
        wr(OFS_CMP_A, 32'h00000003);
        wr(OFS_COUNT, 32'h00000000);
        for (int i = 0; i < 10; i++) begin
            ticks(1);
            chk();
        end
        wr(OFS_CTRL, 32'h00000104);
        ticks(8);
        chk();
        wr(OFS_CTRL, 32'h0000039C);
        wr(OFS_COUNT, 32'h00000008);
        wr(OFS_TOP, 32'h00000005);
        ticks(65527);
        for (int i = 0; i < 8; i++) begin
            ticks(1);
            chk();
        end
        foreach (modes[k]) begin
            wr(OFS_CTRL, 32'h0);
            wr(OFS_CMP_A, 32'h2);
            wr(OFS_COUNT, 32'h0);
            seed = lfsr(seed);
            t = (seed & 16'h003F) | 3;
            wr(OFS_TOP, t);
            wr(OFS_CTRL, 32'h300 | (coms[k] << 6) | (coms[k] << 4) | modes[k]);
            seed = lfsr(seed);
            // Compare values stay at or below TOP so every channel still matches.
            wr(OFS_CMP_A, modes[k] == 4'hF ? t : modes[k] == 4'hE ? seed % (t + 1)
                          : seed | 32'hF000);
            wr(OFS_CMP_B, seed % (t + 1));
            rd(OFS_CMP_A, mbufa, "buffer");
            for (int i = 0; i < 24; i++) begin
                seed = lfsr(seed);
                ticks(1 + seed % (modes[k] > 4'h7 ? 8 : 32 << (modes[k] - 5)));
                chk();
            end
        end
        wr(OFS_CTRL, 32'h00000001);
        ticks(5);
        chk();
        summarize();
    end
endmodule : tb

// ### bench/tmr16_load.sv
// External load on waveform pin A: works out the level that the outside world sees.
// Assumes an active-low output enable and no pull on the line.
`timescale 1ns/1ps
module tmr16_load (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_wave,
    input  wire logic i_oen,
    output logic      o_pin
);
    logic last_q;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            last_q <= 1'b0;
        end else if (!i_oen) begin
            last_q <= i_wave;
        end
    end
    // An undriven line shows the inverse of its last level, so a stale value never matches.
    assign o_pin = i_oen ? ~last_q : i_wave;
endmodule : tmr16_load

// ### core/tmr16_cmp_ch.sv
// One output compare channel: double-buffered compare value, comparator and waveform bit.
// Assumes the parent supplies the mode class, the TOP event and the write-block qualifier.
`timescale 1ns/1ps
module tmr16_cmp_ch (
    input  wire logic                  i_clk,
    input  wire logic                  i_rstn,
    input  wire logic                  i_tick,
    input  wire logic [15:0]           i_count,
    input  wire logic                  i_block,
    input  wire logic                  i_pwm,
    input  wire logic                  i_top_evt,
    input  wire logic                  i_toggle_ok,
    input  wire logic [1:0]            i_act,
    input  wire logic                  i_force,
    input  wire logic                  i_wr,
    input  wire logic [15:0]           i_wdata,
    output logic      [15:0]           o_cmp,
    output logic      [15:0]           o_buf,
    output logic                       o_match,
    output logic                       o_wave
);
    import tmr16_pkg::*;

    logic [15:0] cmp_q;
    logic [15:0] buf_q;
    logic        wave_q;

    // Software always lands in the buffer; outside PWM it also goes straight through.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            buf_q <= RST_WORD;
        end else if (i_wr) begin
            buf_q <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmp_q <= RST_WORD;
        end else if (i_wr && !i_pwm) begin
            cmp_q <= i_wdata;
        end else if (i_pwm && i_tick && i_top_evt) begin
            cmp_q <= buf_q;
        end
    end

    assign o_match = (i_count == cmp_q) && !i_block;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wave_q <= 1'b0;
        end else if (i_pwm) begin
            if (i_tick) begin
                if (i_act == ACT_TOGGLE) begin
                    if (i_toggle_ok && o_match) begin
                        wave_q <= !wave_q;
                    end
                end else if (i_act != ACT_NONE) begin
                    // The BOTTOM action wins so that compare equal to TOP gives a constant level.
                    if (i_top_evt) begin
                        wave_q <= (i_act == ACT_CLEAR);
                    end else if (o_match) begin
                        wave_q <= (i_act == ACT_SET);
                    end
                end
            end
        end else if ((i_tick && o_match) || i_force) begin
            case (i_act)
                ACT_TOGGLE: wave_q <= !wave_q;
                ACT_CLEAR:  wave_q <= 1'b0;
                ACT_SET:    wave_q <= 1'b1;
                default:    wave_q <= wave_q;
            endcase
        end
    end

    assign o_cmp  = cmp_q;
    assign o_buf  = buf_q;
    assign o_wave = wave_q;

endmodule : tmr16_cmp_ch

// ### core/tmr16_core.sv
// Counting and waveform logic of the 16-bit timer with its APB register slave.
// Assumes i_tick is a one-cycle prescaled enable in the i_clk domain and APB is synchronous.
//
// Functional notes
// - Count sequence follows only the mode select; output actions only steer pins.
// - Mode 0 always increments, wraps 0xFFFF to 0x0000, never clears on compare.
// - Normal mode sets overflow flag when the count becomes zero; a flag write or service clears it.
// - Overflow flag clears automatically when its interrupt is serviced.
// - Compare-clear mode clears count on match with compare A (4) or top register (12).
// - Compare-clear TOP match sets compare A flag or capture flag, per TOP source.
// - Compare-clear TOP unbuffered; a TOP below count makes counter run through 0xFFFF.
// - Compare-clear action 1 toggles output A per match; pin visible when direction set.
// - Compare-clear mode still sets overflow flag when count rolls from maximum to 0x0000.
// - Modes 5, 6, 7, 14, 15 are fast PWM: count BOTTOM to TOP, restart.
// - Non-inverting clears on match, sets at BOTTOM; inverting does the opposite.
// - Fast PWM TOP is 0xFF, 0x1FF, 0x3FF, top register or compare A.
// - Fast PWM sets each channel flag when count equals its compare value.
// - Fast PWM sets overflow at TOP, plus the TOP source's own flag.
// - Fixed-TOP fast PWM masks compare write bits above the resolution to zero.
// - Fast PWM top register acts at once; below count it wraps via 0xFFFF.
// - Fast PWM compare A writes are buffered and loaded at TOP.
// - Output action 0 leaves the waveform output unchanged in every mode.
// - Fast PWM action 2 is non-inverted, action 3 inverted.
// - A count write suppresses all compare matches on the next timer tick.
// - Force strobe in non-PWM modes updates output only, no flag, no clear.
`timescale 1ns/1ps
module tmr16_core (
    input  wire logic                  i_clk,
    input  wire logic                  i_rstn,
    input  wire logic                  i_tick,
    input  wire logic                  i_ovf_serviced,
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [7:0]            i_paddr,
    input  wire logic [31:0]           i_pwdata,
    output logic      [31:0]           o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    output logic                       o_wave_a,
    output logic                       o_wave_a_oen,
    output logic                       o_wave_b,
    output logic                       o_wave_b_oen,
    output logic                       o_out_of_scope,
    output tmr16_pkg::tmr16_mode_t     o_mode
);
    import tmr16_pkg::*;

    tmr16_ctrl_t ctrl_q;
    tmr16_mode_t mode;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] top_reg_q;
    logic [3:0]  flags_q;
    logic [31:0] prdata_q;
    logic        block_q;
    logic [15:0] top_val;
    logic [15:0] wmask;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic        match_a;
    logic        match_b;
    logic        at_top;
    logic        top_evt;
    logic        pwm;
    logic        setup;
    logic        wr_en;
    logic        mapped;
    logic        wr_cmp_a;
    logic        wr_cmp_b;
    logic        frc_a;
    logic        frc_b;
    logic [3:0]  flag_set;
    logic [3:0]  flag_clr;

    // APB decode: zero wait states, read data captured in the setup cycle.
    assign setup  = i_psel && !i_penable;
    assign wr_en  = i_psel && i_penable && i_pwrite && mapped;
    assign mapped = (i_paddr == OFS_CTRL) || (i_paddr == OFS_COUNT) ||
                    (i_paddr == OFS_CMP_A) || (i_paddr == OFS_CMP_B) ||
                    (i_paddr == OFS_TOP) || (i_paddr == OFS_FLAGS) ||
                    (i_paddr == OFS_FORCE);
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped;

    // Mode class derives from the mode select field alone.
    always_comb begin
        case (ctrl_q.sel)
            SEL_NORMAL:                           mode = MC_NORMAL;
            SEL_CLR_CMPA, SEL_CLR_TOP:            mode = MC_CLR;
            SEL_FPWM_8, SEL_FPWM_9, SEL_FPWM_10,
            SEL_FPWM_TOP, SEL_FPWM_A:             mode = MC_FPWM;
            default:                              mode = MC_OTHER;
        endcase
    end
    assign pwm = (mode == MC_FPWM);

    always_comb begin
        case (ctrl_q.sel)
            SEL_CLR_CMPA, SEL_FPWM_A: top_val = cmp_a;
            SEL_CLR_TOP, SEL_FPWM_TOP: top_val = top_reg_q;
            SEL_FPWM_8:               top_val = TOP_8BIT;
            SEL_FPWM_9:               top_val = TOP_9BIT;
            SEL_FPWM_10:              top_val = TOP_10BIT;
            default:                  top_val = CNT_MAX;
        endcase
    end

    // Fixed-TOP modes clip compare writes to their resolution.
    always_comb begin
        case (ctrl_q.sel)
            SEL_FPWM_8:  wmask = TOP_8BIT;
            SEL_FPWM_9:  wmask = TOP_9BIT;
            SEL_FPWM_10: wmask = TOP_10BIT;
            default:     wmask = CNT_MAX;
        endcase
    end

    // A TOP below the count is simply passed by, so the count wraps through 0xFFFF first.
    assign at_top  = ((mode == MC_CLR) || pwm) && (count_q == top_val) && !block_q;
    assign top_evt = at_top && pwm;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_q <= tmr16_ctrl_t'(RST_CTRL);
        end else if (wr_en && i_paddr == OFS_CTRL) begin
            ctrl_q <= tmr16_ctrl_t'(i_pwdata[9:0]);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            top_reg_q <= RST_WORD;
        end else if (wr_en && i_paddr == OFS_TOP) begin
            top_reg_q <= i_pwdata[15:0];
        end
    end

    always_comb begin
        count_d = count_q;
        if (i_tick && mode != MC_OTHER) begin
            if (at_top) begin
                count_d = CNT_BOT;
            end else begin
                count_d = count_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            count_q <= RST_WORD;
        end else if (wr_en && i_paddr == OFS_COUNT) begin
            count_q <= i_pwdata[15:0];
        end else begin
            count_q <= count_d;
        end
    end

    // The block lasts until the next tick, however long the timer stands still.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            block_q <= 1'b0;
        end else if (wr_en && i_paddr == OFS_COUNT) begin
            block_q <= 1'b1;
        end else if (i_tick) begin
            block_q <= 1'b0;
        end
    end

    always_comb begin
        flag_set = 4'h0;
        if (i_tick && mode != MC_OTHER) begin
            flag_set[FLG_OVF]   = (count_q == CNT_MAX) || top_evt;
            flag_set[FLG_CMP_A] = match_a;
            flag_set[FLG_CMP_B] = match_b;
            flag_set[FLG_CAPT]  = at_top && (ctrl_q.sel == SEL_CLR_TOP ||
                                             ctrl_q.sel == SEL_FPWM_TOP);
        end
    end

    always_comb begin
        flag_clr = 4'h0;
        if (wr_en && i_paddr == OFS_FLAGS) begin
            flag_clr = i_pwdata[3:0];
        end
        flag_clr[FLG_OVF] = flag_clr[FLG_OVF] || i_ovf_serviced;
    end

    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flags_q <= 4'h0;
        end else begin
            flags_q <= flag_set | (flags_q & ~flag_clr);
        end
    end

    assign wr_cmp_a = wr_en && (i_paddr == OFS_CMP_A);
    assign wr_cmp_b = wr_en && (i_paddr == OFS_CMP_B);
    assign frc_a    = wr_en && (i_paddr == OFS_FORCE) && i_pwdata[FRC_A] && !pwm;
    assign frc_b    = wr_en && (i_paddr == OFS_FORCE) && i_pwdata[FRC_B] && !pwm;

    tmr16_cmp_ch u_ch_a (
        .i_clk       (i_clk),
        .i_rstn      (i_rstn),
        .i_tick      (i_tick),
        .i_count     (count_q),
        .i_block     (block_q),
        .i_pwm       (pwm),
        .i_top_evt   (top_evt),
        .i_toggle_ok (ctrl_q.sel == SEL_FPWM_A),
        .i_act       (ctrl_q.act_a),
        .i_force     (frc_a),
        .i_wr        (wr_cmp_a),
        .i_wdata     (i_pwdata[15:0] & wmask),
        .o_cmp       (cmp_a),
        .o_buf       (buf_a),
        .o_match     (match_a),
        .o_wave      (o_wave_a)
    );

    tmr16_cmp_ch u_ch_b (
        .i_clk       (i_clk),
        .i_rstn      (i_rstn),
        .i_tick      (i_tick),
        .i_count     (count_q),
        .i_block     (block_q),
        .i_pwm       (pwm),
        .i_top_evt   (top_evt),
        .i_toggle_ok (1'b0),
        .i_act       (ctrl_q.act_b),
        .i_force     (frc_b),
        .i_wr        (wr_cmp_b),
        .i_wdata     (i_pwdata[15:0] & wmask),
        .o_cmp       (cmp_b),
        .o_buf       (buf_b),
        .o_match     (match_b),
        .o_wave      (o_wave_b)
    );

    // Enables are low while the pin is driven by the waveform bit.
    assign o_wave_a_oen   = !(ctrl_q.dir_a && ctrl_q.act_a != ACT_NONE);
    assign o_wave_b_oen   = !(ctrl_q.dir_b && ctrl_q.act_b != ACT_NONE);
    assign o_out_of_scope = (mode == MC_OTHER);
    assign o_mode         = mode;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            case (i_paddr)
                OFS_CTRL:  prdata_q <= {22'h00_0000, ctrl_q};
                OFS_COUNT: prdata_q <= {16'h0000, count_q};
                OFS_CMP_A: prdata_q <= {16'h0000, pwm ? buf_a : cmp_a};
                OFS_CMP_B: prdata_q <= {16'h0000, pwm ? buf_b : cmp_b};
                OFS_TOP:   prdata_q <= {16'h0000, top_reg_q};
                OFS_FLAGS: prdata_q <= {28'h000_0000, flags_q};
                default:   prdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign o_prdata = prdata_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_top_tick;
        i_tick && top_evt && !(wr_en && i_paddr == OFS_COUNT);
    endsequence

    a_normal_wrap: assert property (
        (i_tick && mode == MC_NORMAL && count_q == CNT_MAX && !wr_en)
        |=> count_q == CNT_BOT)
        else $error("normal mode did not wrap to zero");

    a_normal_incr: assert property (
        (i_tick && mode == MC_NORMAL && !wr_en) |=> count_q == $past(count_q) + 16'h0001)
        else $error("normal mode did not increment");

    a_ovf_set: assert property (
        (i_tick && mode != MC_OTHER && count_q == CNT_MAX) |=> flags_q[FLG_OVF])
        else $error("overflow flag not set on wrap");

    a_ovf_service: assert property (
        (i_ovf_serviced && !flag_set[FLG_OVF]) |=> !flags_q[FLG_OVF])
        else $error("overflow flag not cleared on service");

    a_clr_count: assert property (
        (i_tick && mode == MC_CLR && at_top && !wr_en) |=> count_q == CNT_BOT)
        else $error("compare-clear mode did not clear at top");

    a_clr_flag: assert property (
        (i_tick && at_top && ctrl_q.sel == SEL_CLR_TOP) |=> flags_q[FLG_CAPT])
        else $error("capture flag not set at compare-clear top");

    a_pwm_top_load: assert property (
        s_top_tick ##0 (buf_a != cmp_a) |=> (cmp_a == $past(buf_a)) && flags_q[FLG_OVF])
        else $error("compare buffer not loaded at top");

    a_block_match: assert property (
        (wr_en && i_paddr == OFS_COUNT) |=> !match_a && !match_b && !at_top)
        else $error("match not blocked after count write");

    a_scope_hold: assert property (
        (mode == MC_OTHER && !wr_en) [*2] |-> $stable(count_q))
        else $error("counter moved in out-of-scope mode");

    a_force_noflag: assert property (
        (frc_a && !i_tick) |=> flags_q[FLG_CMP_A] == $past(flags_q[FLG_CMP_A]))
        else $error("force strobe set a flag");

endmodule : tmr16_core

// ### core/tmr16_pkg.sv
// Shared constants and types of the 16-bit timer: register map, mode codes and TOP values.
// Assumes a single system clock; the prescaled timer tick arrives as a one-cycle enable.
package tmr16_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_COUNT    = 8'h04;
    localparam logic [7:0] OFS_CMP_A    = 8'h08;
    localparam logic [7:0] OFS_CMP_B    = 8'h0C;
    localparam logic [7:0] OFS_TOP      = 8'h10;
    localparam logic [7:0] OFS_FLAGS    = 8'h14;
    localparam logic [7:0] OFS_FORCE    = 8'h18;

    // Flag bit positions in the flag register.
    localparam int FLG_OVF   = 0;
    localparam int FLG_CMP_A = 1;
    localparam int FLG_CMP_B = 2;
    localparam int FLG_CAPT  = 3;

    // Force strobe bit positions.
    localparam int FRC_A = 0;
    localparam int FRC_B = 1;

    // Waveform mode select encodings handled here.
    localparam logic [3:0] SEL_NORMAL   = 4'h0;
    localparam logic [3:0] SEL_CLR_CMPA = 4'h4;
    localparam logic [3:0] SEL_FPWM_8   = 4'h5;
    localparam logic [3:0] SEL_FPWM_9   = 4'h6;
    localparam logic [3:0] SEL_FPWM_10  = 4'h7;
    localparam logic [3:0] SEL_CLR_TOP  = 4'hC;
    localparam logic [3:0] SEL_FPWM_TOP = 4'hE;
    localparam logic [3:0] SEL_FPWM_A   = 4'hF;

    // Compare output action encodings.
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;

    // Fixed TOP values and the extremes of the count.
    localparam logic [15:0] TOP_8BIT  = 16'h00FF;
    localparam logic [15:0] TOP_9BIT  = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] CNT_BOT   = 16'h0000;

    // Reset values.
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [9:0]  RST_CTRL  = 10'h000;

    // Control register layout, high bits first down to wgm.
    typedef struct packed {
        logic       dir_b;
        logic       dir_a;
        logic [1:0] act_b;
        logic [1:0] act_a;
        logic [3:0] sel;
    } tmr16_ctrl_t;

    // Mode classes, one-hot.
    typedef enum logic [3:0] {
        MC_NORMAL = 4'b0001,
        MC_CLR    = 4'b0010,
        MC_FPWM   = 4'b0100,
        MC_OTHER  = 4'b1000
    } tmr16_mode_t;

endpackage : tmr16_pkg
